// [include/serial_unit_defines.vh]
// serial unit constants: control bit positions, reset value, clock divisors
// assumes inclusion by bare name from the design file
`ifndef SERIAL_UNIT_DEFINES_VH
`define SERIAL_UNIT_DEFINES_VH
`define CTRL_TX_IRQ_EN 7
`define CTRL_RX_IRQ_EN 6
`define CTRL_TX_ON 5
`define CTRL_RX_ON 4
`define CTRL_ADDR_WAIT_EN 3
`define CTRL_TX_DONE_IRQ_EN 2
`define CTRL_CLK_SRC_SEL_HI 1
`define CTRL_CLK_SRC_SEL_LO 0
`define CTRL_RESET 8'h00
`define BAUD_DIV 13
`define SYNC_HALF 4
`define FIFO_DEPTH 4
`define FIFO_AW 2
`endif

// [hdl/serial_unit.v]
// serial unit: control register, tx fifo, async/clocked-sync tx and rx, clock pin control
// assumes mode bits come from logic on clk_i; rxd_i and sck_i come from pins
`timescale 1ns/1ps
`include "serial_unit_defines.vh"

module tx_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire clk_i, // system clock
  input wire arst_n_i, // async reset, active low
  input wire [WIDTH-1:0] in_data_i, // write data
  input wire in_valid_i, // write request
  output wire in_ready_o, // space available
  output wire [WIDTH-1:0] out_data_o, // head word
  output wire out_valid_o, // head valid
  input wire out_ready_i // pop head
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign in_ready_o = (cnt_r != DEPTH);
  assign out_valid_o = (cnt_r != 0);
  assign out_data_o = mem[rp_r];
  // storage
  always @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end
  // pointers and fill count
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      if (push & ~pop) cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

module serial_unit #(
  parameter BAUD_DIV = `BAUD_DIV,
  parameter SYNC_HALF = `SYNC_HALF
) (
  input wire clk_i, // system clock
  input wire arst_n_i, // async reset, active low
  input wire ctrl_wr_i, // control write strobe
  input wire [7:0] ctrl_wdata_i, // control write data
  output wire [7:0] ctrl_rdata_o, // control read data
  input wire mode_sync_i, // 0 async, 1 clocked sync
  input wire multiproc_mode_i, // multiprocessor framing
  input wire [8:0] tx_data_i, // {mp bit, byte}
  input wire tx_valid_i, // tx word offered
  output wire tx_ready_o, // tx fifo has room
  output reg [7:0] rx_data_o, // received byte
  output reg rx_mpb_o, // received mp bit
  output reg rx_data_full_o, // received byte waiting
  output reg framing_error_o, // stop bit was 0
  output reg overrun_flag_o, // byte lost while full
  input wire rx_clr_i, // clears rx flags
  output reg tx_empty_irq_o, // transmit-empty request
  output reg rx_full_irq_o, // receive-full request
  output reg rx_fault_irq_o, // receive-error request
  output reg tx_done_irq_o, // transmit-complete request
  output wire txd_o, // serial data out
  input wire rxd_i, // serial data in
  input wire sck_i, // clock pin input
  output reg sck_o, // clock pin output
  output reg sck_oe_o // clock pin drive enable
);
  reg [7:0] ctrl_r;
  reg rxd_m_r, rxd_s_r, rxd_d_r, sck_m_r, sck_s_r, sck_d_r;
  reg [7:0] div_r;
  reg [3:0] ph16_r;
  reg tx_busy_r, rx_busy_r, sy_busy_r, sck_int_r;
  reg [3:0] tc16_r, rc16_r, tidx_r, ridx_r;
  reg [10:0] tsh_r, rsh_r;
  reg [7:0] hc_r;
  reg [3:0] sidx_r;
  wire [8:0] f_data;
  wire f_valid, f_pop;
  wire tx_on = ctrl_r[`CTRL_TX_ON];
  wire rx_on = ctrl_r[`CTRL_RX_ON];
  wire sel_hi = ctrl_r[`CTRL_CLK_SRC_SEL_HI];
  wire mp_eff = multiproc_mode_i & ~mode_sync_i;
  // address wait counts only in async multiprocessor mode
  wire wait_eff = ctrl_r[`CTRL_ADDR_WAIT_EN] & mp_eff;
  wire busy = tx_busy_r | rx_busy_r | sy_busy_r;
  wire sck_rise = sck_s_r & ~sck_d_r;
  wire sck_fall = ~sck_s_r & sck_d_r;
  wire div_done = (div_r == BAUD_DIV - 1);
  // async timing: internal divider or external 16x clock
  wire tick16 = sel_hi ? sck_rise : div_done;
  wire hc_done = (hc_r == SYNC_HALF - 1);
  // sync events: own clock or remote clock
  wire s_rise = sy_busy_r & (sel_hi ? sck_rise : (hc_done & ~sck_int_r));
  wire s_fall = sy_busy_r & (sel_hi ? sck_fall : (hc_done & sck_int_r));
  wire [3:0] tx_last = mp_eff ? 4'hA : 4'h9;
  wire [10:0] fin = {rxd_s_r, rsh_r[10:1]};
  wire rx_done_a = rx_busy_r & tick16 & (rc16_r == 4'h7) & (ridx_r == tx_last);
  wire rx_done_s = s_rise & (sidx_r == 4'h7);
  wire mpb_in = mp_eff & fin[9];
  wire [7:0] byte_in = mode_sync_i ? {rxd_s_r, rsh_r[10:4]} : (mp_eff ? fin[8:1] : fin[9:2]);
  wire stop_in = mode_sync_i | fin[10];
  wire rx_done = rx_done_a | (rx_done_s & rx_on);
  // drop frames with mp bit 0 while waiting
  wire rx_skip = wait_eff & ~mpb_in;
  wire aw_clr = rx_done_a & wait_eff & mpb_in;
  wire sy_start = mode_sync_i & ~sy_busy_r & ((tx_on & f_valid) | (rx_on & ~tx_on & ~rx_data_full_o));
  wire tx_end = ~tx_on | (~tx_busy_r & ~sy_busy_r & ~f_valid);

  tx_fifo #(.WIDTH(9), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop)
  );

  // pop head when an async frame or sync transfer starts
  assign f_pop = tx_on & f_valid & ((~mode_sync_i & ~tx_busy_r) | sy_start);
  assign ctrl_rdata_o = ctrl_r;
  assign txd_o = tsh_r[0];

  // control register; idle-only writes, hardware clears address wait
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= `CTRL_RESET;
    end else if (ctrl_wr_i && !busy) begin
      ctrl_r <= ctrl_wdata_i;
    end else if (aw_clr) begin
      ctrl_r[`CTRL_ADDR_WAIT_EN] <= 1'b0;
    end
  end

  // pin synchronisers and edge history
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxd_m_r <= 1'b1;
      rxd_s_r <= 1'b1;
      rxd_d_r <= 1'b1;
      sck_m_r <= 1'b1; // idle level, no false edge after reset
      sck_s_r <= 1'b1;
      sck_d_r <= 1'b1;
    end else begin
      rxd_m_r <= rxd_i;
      rxd_s_r <= rxd_m_r;
      rxd_d_r <= rxd_s_r;
      sck_m_r <= sck_i;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
    end
  end

  // baud divider and 16x phase for bit-rate clock out
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r <= 8'h00;
      ph16_r <= 4'h0;
    end else begin
      div_r <= div_done ? 8'h00 : div_r + 8'h01;
      if (tick16) ph16_r <= ph16_r + 4'h1;
    end
  end

  // clock pin direction and level
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_o <= 1'b1;
      sck_oe_o <= 1'b0;
    end else if (mode_sync_i) begin
      sck_o <= sck_int_r;
      sck_oe_o <= ~sel_hi;
    end else begin
      sck_o <= ~sel_hi & ctrl_r[`CTRL_CLK_SRC_SEL_LO] ? ph16_r[3] : 1'b1;
      sck_oe_o <= ~sel_hi & ctrl_r[`CTRL_CLK_SRC_SEL_LO];
    end
  end

  // transmitter: async frames and sync shift-out
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_busy_r <= 1'b0;
      tc16_r <= 4'h0;
      tidx_r <= 4'h0;
      tsh_r <= 11'h7FF;
    end else if (!tx_on) begin
      tx_busy_r <= 1'b0;
      tsh_r <= 11'h7FF;
    end else if (mode_sync_i) begin
      tx_busy_r <= 1'b0;
      if (sy_start) tsh_r <= f_valid ? {3'b111, f_data[7:0]} : 11'h7FF;
      else if (s_fall && sidx_r != 4'h0) tsh_r <= {1'b1, tsh_r[10:1]};
    end else if (!tx_busy_r) begin
      if (f_valid) begin
        tx_busy_r <= 1'b1;
        tc16_r <= 4'h0;
        tidx_r <= 4'h0;
        // mp bit takes the parity slot in multiproc framing
        tsh_r <= mp_eff ? {1'b1, f_data[8], f_data[7:0], 1'b0} : {2'b11, f_data[7:0], 1'b0};
      end
    end else if (tick16) begin
      tc16_r <= tc16_r + 4'h1;
      if (tc16_r == 4'hF) begin
        tsh_r <= {1'b1, tsh_r[10:1]};
        tidx_r <= tidx_r + 4'h1;
        if (tidx_r == tx_last) tx_busy_r <= 1'b0;
      end
    end
  end

  // sync transfer engine and internal transfer clock
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sy_busy_r <= 1'b0;
      sck_int_r <= 1'b1;
      hc_r <= 8'h00;
      sidx_r <= 4'h0;
    end else if (!mode_sync_i || !(tx_on | rx_on)) begin
      sy_busy_r <= 1'b0;
      sck_int_r <= 1'b1;
      hc_r <= 8'h00;
      sidx_r <= 4'h0;
    end else if (sy_start) begin
      sy_busy_r <= 1'b1;
      hc_r <= 8'h00;
      sidx_r <= 4'h0;
    end else if (sy_busy_r) begin
      hc_r <= hc_done ? 8'h00 : hc_r + 8'h01;
      if (!sel_hi && hc_done) sck_int_r <= ~sck_int_r;
      if (s_rise) begin
        sidx_r <= sidx_r + 4'h1;
        if (sidx_r == 4'h7) sy_busy_r <= 1'b0;
      end
    end
  end

  // async receiver sampling at bit centres
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_busy_r <= 1'b0;
      rc16_r <= 4'h0;
      ridx_r <= 4'h0;
      rsh_r <= 11'h000;
    end else if (!rx_on) begin
      rx_busy_r <= 1'b0;
    end else if (mode_sync_i) begin
      rx_busy_r <= 1'b0;
      if (s_rise) rsh_r <= {rxd_s_r, rsh_r[10:1]};
    end else if (!rx_busy_r) begin
      if (rxd_d_r && !rxd_s_r) begin // falling edge only, a held-low line after a bad stop is no start
        rx_busy_r <= 1'b1;
        rc16_r <= 4'h0;
        ridx_r <= 4'h0;
      end
    end else if (tick16) begin
      rc16_r <= rc16_r + 4'h1;
      if (rc16_r == 4'h7) begin
        rsh_r <= {rxd_s_r, rsh_r[10:1]};
        ridx_r <= ridx_r + 4'h1;
        if (ridx_r == 4'h0 && rxd_s_r) rx_busy_r <= 1'b0; // false start
        if (ridx_r == tx_last) rx_busy_r <= 1'b0;
      end
    end
  end

  // receive data and flags; a new event wins over a clear
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_data_o <= 8'h00;
      rx_mpb_o <= 1'b0;
      rx_data_full_o <= 1'b0;
      framing_error_o <= 1'b0;
      overrun_flag_o <= 1'b0;
    end else begin
      if (rx_clr_i) begin
        rx_data_full_o <= 1'b0;
        framing_error_o <= 1'b0;
        overrun_flag_o <= 1'b0;
      end
      if (rx_done && !rx_skip) begin
        if (rx_data_full_o && !rx_clr_i) begin
          overrun_flag_o <= 1'b1;
        end else begin
          rx_data_o <= byte_in;
          rx_mpb_o <= mpb_in;
          rx_data_full_o <= 1'b1;
        end
        if (!stop_in) framing_error_o <= 1'b1;
      end
    end
  end

  // interrupt requests gated by enables
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_empty_irq_o <= 1'b0;
      rx_full_irq_o <= 1'b0;
      rx_fault_irq_o <= 1'b0;
      tx_done_irq_o <= 1'b0;
    end else begin
      tx_empty_irq_o <= ctrl_r[`CTRL_TX_IRQ_EN] & tx_on & tx_ready_o;
      rx_full_irq_o <= ctrl_r[`CTRL_RX_IRQ_EN] & rx_data_full_o;
      rx_fault_irq_o <= ctrl_r[`CTRL_RX_IRQ_EN] & (framing_error_o | overrun_flag_o);
      tx_done_irq_o <= ctrl_r[`CTRL_TX_DONE_IRQ_EN] & tx_end;
    end
  end
endmodule

// [testbench/serial_unit_asserts.sv]
// checker on serial unit ports: request gating, clock pin drive, address wait
// assumes bind onto serial_unit, one clock domain
`timescale 1ns/1ps
module serial_unit_asserts (
  input wire clk_i, // system clock
  input wire arst_n_i, // async reset, active low
  input wire [7:0] ctrl_rdata_o, // control contents
  input wire mode_sync_i, // mode select
  input wire multiproc_mode_i, // multiproc framing
  input wire tx_ready_o, // fifo room
  input wire rx_data_full_o, // rx full
  input wire rx_mpb_o, // rx mp bit
  input wire framing_error_o, // stop bit low
  input wire overrun_flag_o, // byte lost
  input wire tx_empty_irq_o, // tx empty request
  input wire rx_full_irq_o, // rx full request
  input wire rx_fault_irq_o, // rx fault request
  input wire tx_done_irq_o, // tx done request
  input wire txd_o, // serial out
  input wire sck_oe_o // clock pin drive
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // address wait only counts in async multiproc
  wire wait_on = ctrl_rdata_o[3] & multiproc_mode_i & ~mode_sync_i;
  // requests follow their enables one cycle later
  tx_empty_gate_a: assert property (tx_empty_irq_o == $past(ctrl_rdata_o[7] & ctrl_rdata_o[5] & tx_ready_o))
    else $error("tx empty request wrong");
  rx_full_gate_a: assert property (rx_full_irq_o == $past(ctrl_rdata_o[6] & rx_data_full_o))
    else $error("rx full request wrong");
  rx_fault_gate_a: assert property (rx_fault_irq_o == $past(ctrl_rdata_o[6] & (framing_error_o | overrun_flag_o)))
    else $error("rx fault request wrong");
  tx_done_gate_a: assert property (tx_done_irq_o |-> $past(ctrl_rdata_o[2]))
    else $error("tx done request unmasked");
  tx_idle_off_a: assert property (!ctrl_rdata_o[5] |-> txd_o)
    else $error("txd active while tx off");
  rx_needs_on_a: assert property ($rose(rx_data_full_o) |-> $past(ctrl_rdata_o[4]))
    else $error("rx data while rx off");
  wait_skip_a: assert property (($rose(rx_data_full_o) || $rose(framing_error_o)) && $past(wait_on) |-> rx_mpb_o)
    else $error("frame kept during address wait");
  wait_clear_a: assert property ($rose(rx_data_full_o) && rx_mpb_o && $past(wait_on) |-> ##[0:1] !ctrl_rdata_o[3])
    else $error("address wait not cleared");
  sck_drive_sel_a: assert property (sck_oe_o == $past(mode_sync_i ? !ctrl_rdata_o[1] : ctrl_rdata_o[1:0] == 2'b01))
    else $error("clock pin drive wrong");
  fifo_full_c: cover property ($fell(tx_ready_o));
  rx_full_c: cover property ($rose(rx_data_full_o));
  wait_clear_c: cover property ($fell(ctrl_rdata_o[3]));
endmodule

// [testbench/serial_link_model.sv]
// remote transceiver model: async frames both ways, clocked sync sender
// assumes BIT_CYC system cycles per bit; its clock stands high outside frames
`timescale 1ns/1ps
module serial_link_model #(
  parameter BIT_CYC = 32
) (
  input wire clk_i, // system clock
  input wire txd_i, // line from device
  output reg rxd_o, // line to device, idle high
  output reg sck_o // clock into pin, pulled high
);
  reg [10:0] f;
  integer i;
  integer j;
  initial begin
    rxd_o = 1'b1;
    sck_o = 1'b1;
  end
  // async frame out: start, lsb first, mp bit if enabled, stop, no parity
  task send(input [8:0] w, input mp_en, input stop);
    begin
      f = mp_en ? {stop, w, 1'b0} : {1'b1, stop, w[7:0], 1'b0};
      for (i = 0; i < (mp_en ? 11 : 10); i = i + 1) begin
        @(posedge clk_i);
        rxd_o <= f[i];
        repeat (BIT_CYC - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      rxd_o <= 1'b1;
    end
  endtask
  // async frame in: mid-bit samples, gives {stop, byte} at mid stop
  task recv(output [8:0] w);
    begin
      @(negedge txd_i);
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (j = 0; j < 9; j = j + 1) begin
        repeat (BIT_CYC) @(posedge clk_i);
        w[j] = txd_i;
      end
    end
  endtask
  // sync byte out: data on fall, 8 rises at 320 ns, phase free of clk_i
  task sync_send(input [7:0] b);
    begin
      #13;
      for (i = 0; i < 8; i = i + 1) begin
        rxd_o = b[i];
        sck_o = 1'b0;
        #160;
        sck_o = 1'b1;
        #160;
      end
      rxd_o = 1'b1;
    end
  endtask
endmodule

// [testbench/serial_unit_tb_top.sv]
// bench for serial unit: control, clock pin, fifo, tx, rx flags, address wait
// assumes serial_link_model as far side; BAUD_DIV 2 gives 32 cycles a bit
`timescale 1ns/1ps
module serial_unit_tb_top;
  reg clk_i, arst_n_i, ctrl_wr_i, mode_sync_i, multiproc_mode_i, tx_valid_i, rx_clr_i;
  reg [7:0] ctrl_wdata_i;
  reg [8:0] tx_data_i, got;
  wire [7:0] ctrl_rdata_o, rx_data_o;
  wire rx_mpb_o, rx_data_full_o, framing_error_o, overrun_flag_o, tx_ready_o, txd_o, rxd_i;
  wire tx_empty_irq_o, rx_full_irq_o, rx_fault_irq_o, tx_done_irq_o, sck_o, sck_oe_o, link_sck;
  wire sck_i = sck_oe_o ? sck_o : link_sck;
  integer n_fail, checks, k;
  serial_unit #(.BAUD_DIV(2), .SYNC_HALF(2)) i_dut (.clk_i, .arst_n_i, .ctrl_wr_i, .ctrl_wdata_i,
    .ctrl_rdata_o, .mode_sync_i, .multiproc_mode_i, .tx_data_i, .tx_valid_i, .tx_ready_o, .rx_data_o,
    .rx_mpb_o, .rx_data_full_o, .framing_error_o, .overrun_flag_o, .rx_clr_i, .tx_empty_irq_o,
    .rx_full_irq_o, .rx_fault_irq_o, .tx_done_irq_o, .txd_o, .rxd_i, .sck_i, .sck_o, .sck_oe_o);
  serial_link_model #(.BIT_CYC(32)) i_link (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .sck_o(link_sck));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task complete_run;
    begin
      $display("n_fail %0d checks %0d", n_fail, checks);
      if (n_fail == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("FAIL %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  // control write, only while idle
  task wr(input [7:0] v);
    begin
      @(posedge clk_i);
      ctrl_wr_i <= 1'b1;
      ctrl_wdata_i <= v;
      @(posedge clk_i);
      ctrl_wr_i <= 1'b0;
      cyc(2);
      chk(ctrl_rdata_o, v);
    end
  endtask
  task push(input [8:0] w);
    begin
      @(posedge clk_i);
      tx_data_i <= w;
      tx_valid_i <= 1'b1;
      @(posedge clk_i);
      tx_valid_i <= 1'b0;
    end
  endtask
  task clr;
    begin
      @(posedge clk_i);
      rx_clr_i <= 1'b1;
      @(posedge clk_i);
      rx_clr_i <= 1'b0;
    end
  endtask
  task t_clock_pins;
    for (k = 0; k < 8; k = k + 1) begin
      @(posedge clk_i);
      mode_sync_i <= k[2];
      wr({6'h00, k[1:0]});
      chk(sck_oe_o, k[2] ? !k[1] : (k[1:0] == 2'b01));
      got[0] = sck_o;
      cyc(16);
      if (k == 1) chk(sck_o, !got[0]);
    end
  endtask
  task t_fifo_tx;
    begin
      @(posedge clk_i);
      mode_sync_i <= 1'b0;
      wr(8'h00);
      for (k = 0; k < 4; k = k + 1) push(9'h081 + k * 9'h024);
      #1;
      chk(tx_ready_o, 1'b0);
      push(9'h1ff);
      cyc(50);
      chk(txd_o, 1'b1);
      fork
        wr(8'ha4);
        for (k = 0; k < 4; k = k + 1) begin
          i_link.recv(got);
          chk(got, {1'b1, 8'h81 + k[7:0] * 8'h24});
        end
      join
      cyc(40);
      chk({txd_o, tx_empty_irq_o, tx_done_irq_o}, 3'b111);
      wr(8'h20);
      chk({tx_empty_irq_o, tx_done_irq_o}, 2'b00);
    end
  endtask
  task t_rx_flags;
    begin
      wr(8'h40);
      i_link.send(9'h011, 1'b0, 1'b1);
      cyc(4);
      chk(rx_data_full_o, 1'b0);
      wr(8'h50);
      i_link.send(9'h03c, 1'b0, 1'b1);
      cyc(4);
      chk({rx_data_full_o, rx_data_o}, 9'h13c);
      chk({rx_full_irq_o, rx_fault_irq_o}, 2'b10);
      i_link.send(9'h0c3, 1'b0, 1'b1);
      cyc(4);
      chk({overrun_flag_o, rx_data_o, rx_fault_irq_o}, 10'h279);
      wr(8'h10);
      chk({rx_full_irq_o, rx_fault_irq_o}, 2'b00);
      clr;
      i_link.send(9'h055, 1'b0, 1'b0);
      cyc(4);
      chk({framing_error_o, rx_data_full_o}, 2'b11);
    end
  endtask
  task t_addr_wait;
    begin
      clr;
      @(posedge clk_i);
      multiproc_mode_i <= 1'b1;
      wr(8'h58);
      i_link.send(9'h0aa, 1'b1, 1'b0);
      cyc(4);
      chk({rx_data_full_o, framing_error_o, overrun_flag_o}, 3'b000);
      i_link.send(9'h177, 1'b1, 1'b1);
      cyc(4);
      chk({rx_mpb_o, rx_data_o}, 9'h177);
      chk({ctrl_rdata_o, rx_data_full_o}, 9'h0a1);
      clr;
      @(posedge clk_i);
      multiproc_mode_i <= 1'b0;
      wr(8'h58);
      i_link.send(9'h066, 1'b0, 1'b1);
      cyc(4);
      chk({rx_data_full_o, rx_data_o}, 9'h166);
    end
  endtask
  task t_sync_ext;
    begin
      clr;
      wr(8'h00);
      @(posedge clk_i);
      mode_sync_i <= 1'b1;
      wr(8'h12);
      chk(sck_oe_o, 1'b0);
      i_link.sync_send(8'h9a);
      cyc(6);
      chk({rx_data_full_o, rx_data_o}, 9'h19a);
    end
  endtask
  // watchdog well past the expected run of about 160 us
  initial begin
    #1_000_000;
    n_fail = n_fail + 1;
    complete_run;
  end
  initial begin
    n_fail = 0;
    checks = 0;
    arst_n_i = 1'b0;
    ctrl_wr_i = 1'b0;
    ctrl_wdata_i = 8'h00;
    mode_sync_i = 1'b0;
    multiproc_mode_i = 1'b0;
    tx_valid_i = 1'b0;
    tx_data_i = 9'h000;
    rx_clr_i = 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    cyc(1);
    chk({ctrl_rdata_o, txd_o}, 9'h001);
    chk({sck_oe_o, tx_ready_o}, 2'b01);
    t_clock_pins;
    t_fifo_tx;
    t_rx_flags;
    t_addr_wait;
    t_sync_ext;
    complete_run;
  end
endmodule
bind serial_unit serial_unit_asserts i_chk (.clk_i, .arst_n_i, .ctrl_rdata_o, .mode_sync_i, .multiproc_mode_i,
  .tx_ready_o, .rx_data_full_o, .rx_mpb_o, .framing_error_o, .overrun_flag_o, .tx_empty_irq_o, .rx_full_irq_o,
  .rx_fault_irq_o, .tx_done_irq_o, .txd_o, .sck_oe_o);
